// file: rtl/izw_defs.vh
// izw_defs.vh: constants for the isa data strobe / zero-wait block
// assumes inclusion by bare name from rtl files
`ifndef IZW_DEFS_VH
`define IZW_DEFS_VH

// address space
`define IZW_ADDR_W        24
`define IZW_STD_LIMIT     24'h100000
// data path split
`define IZW_DATA_W        16
`define IZW_HI_MSB        15
`define IZW_HI_LSB        8
`define IZW_LO_MSB        7
`define IZW_LO_LSB        0
// cycle kinds
`define IZW_KIND_W        2
`define IZW_KIND_MEM16    2'h0
`define IZW_KIND_MEM8     2'h1
`define IZW_KIND_IO8      2'h2
`define IZW_KIND_IO16     2'h3
// cycle lengths in bus clocks
`define IZW_LEN_W         4
`define IZW_LEN_MEM16_ZWS 4'h2
`define IZW_LEN_8BIT_ZWS  4'h3
`define IZW_LEN_MEM16     4'h3
`define IZW_LEN_8BIT      4'h6
`define IZW_LEN_IO16      4'h3
// standard strobe delay, in core clocks
`define IZW_SDLY_W        3
`define IZW_SDLY          3'h2

`endif

// file: rtl/izw_sync.v
// izw_sync.v: two-flop synchroniser for a vector of pin levels
// assumes inputs come from outside the i_clk domain
`timescale 1ns/1ns
`default_nettype none
module izw_sync #(
    parameter W  = 1,
    parameter RV = 1'b1
) (
    // clock and reset
    input  wire         i_clk,
    input  wire         i_rst_n,
    input  wire         i_ce,
    // levels
    input  wire [W-1:0] i_d,
    output wire [W-1:0] o_q
);
    reg [W-1:0] meta_q;
    reg [W-1:0] sync_q;

    // first stage only feeds second stage
    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            meta_q <= {W{RV}};
            sync_q <= {W{RV}};
        end else if (i_ce) begin
            meta_q <= i_d;
            sync_q <= meta_q;
        end
    end

    assign o_q = sync_q;
endmodule // izw_sync
`default_nettype wire

// file: rtl/izw_zws.v
// izw_zws.v: bus cycle length counter with zero-wait shortening
// assumes sampled, synchronised pins and a one-cycle bus clock tick
`timescale 1ns/1ns
`default_nettype none
`include "izw_defs.vh"
module izw_zws (
    // clock and reset
    input  wire                   i_clk,
    input  wire                   i_rst_n,
    input  wire                   i_ce,
    // cycle control
    input  wire                   i_start,
    input  wire                   i_tick,
    input  wire [`IZW_KIND_W-1:0] i_kind,
    input  wire                   i_zerows_n,
    input  wire                   i_iochrdy,
    // status
    output reg                    o_busy,
    output reg                    o_done,
    output reg  [`IZW_LEN_W-1:0]  o_clocks
);
    reg [`IZW_LEN_W-1:0]  cnt_q;
    reg [`IZW_LEN_W-1:0]  len_q;
    reg [`IZW_KIND_W-1:0] kind_q;
    reg                   zws_ok;

    // full-length cycle per kind
    function [`IZW_LEN_W-1:0] full_len;
        input [`IZW_KIND_W-1:0] k;
        begin
            if (k == `IZW_KIND_MEM16)
                full_len = `IZW_LEN_MEM16;
            else if (k == `IZW_KIND_IO16)
                full_len = `IZW_LEN_IO16;
            else
                full_len = `IZW_LEN_8BIT;
        end
    endfunction

    // shortened length; io16 never shortens
    function [`IZW_LEN_W-1:0] zws_len;
        input [`IZW_KIND_W-1:0] k;
        begin
            if (k == `IZW_KIND_MEM16)
                zws_len = `IZW_LEN_MEM16_ZWS; // R12
            else if (k == `IZW_KIND_IO16)
                zws_len = `IZW_LEN_IO16; // R14
            else
                zws_len = `IZW_LEN_8BIT_ZWS; // R13
        end
    endfunction

    // not-ready in the same clock cancels the request
    always @* begin
        zws_ok = !i_zerows_n && i_iochrdy; // R15
    end

    // count bus clocks; ends only while iochrdy is high
    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            cnt_q    <= {`IZW_LEN_W{1'b0}};
            len_q    <= {`IZW_LEN_W{1'b0}};
            kind_q   <= `IZW_KIND_MEM16;
            o_busy   <= 1'b0;
            o_done   <= 1'b0;
            o_clocks <= {`IZW_LEN_W{1'b0}};
        end else if (i_ce) begin
            o_done <= 1'b0;
            if (i_start && !o_busy) begin
                kind_q <= i_kind;
                len_q  <= full_len(i_kind);
                cnt_q  <= {`IZW_LEN_W{1'b0}};
                o_busy <= 1'b1;
            end else if (o_busy && i_tick) begin
                if (zws_ok && kind_q != `IZW_KIND_IO16 &&
                    zws_len(kind_q) < len_q)
                    len_q <= zws_len(kind_q);
                cnt_q <= cnt_q + 4'h1;
                // wait states stretch while iochrdy low
                if (i_iochrdy && (cnt_q + 4'h1 >= len_q ||
                    (zws_ok && cnt_q + 4'h1 >= zws_len(kind_q)))) begin
                    o_busy   <= 1'b0;
                    o_done   <= 1'b1;
                    o_clocks <= cnt_q + 4'h1;
                end
            end
        end
    end
endmodule // izw_zws
`default_nettype wire

// file: rtl/izw_top.v
// izw_top.v: isa byte-high enable, data direction, standard memory
// strobes and zero-wait-state cycle shortening.
// assumes neighbour logic supplies ownership, refresh and full strobes.
// Contract
// (R1) byte-high enable asserted whenever the upper data byte moves
// (R2) byte-high enable negated during refresh cycles
// (R3) byte-high enable output when we own the bus, input otherwise; the code also drives it during suspend
// (R4) 16-bit data path, upper lines high byte, lower lines low byte
// (R5) data lines undefined during refresh; nobody relies on them
// (R6) standard read strobe asserted for memory accesses below 1 Mbyte
// (R7) standard read strobe is a delayed copy of full read strobe
// (R8) standard write strobe asserted for memory accesses below 1 Mbyte
// (R9) standard write strobe is a delayed copy of full write strobe
// (R10) write strobe floats in reset, high after reset and in suspend
// (R11) slave asserts zero-wait request after decoding address and command
// (R12) zero-wait request shortens 16-bit memory cycle to two bus clocks
// (R13) zero-wait request shortens 8-bit memory or io cycle to three
// (R14) zero-wait request ignored during 16-bit io cycles
// (R15) zero-wait request ignored when iochrdy negated in same clock
// (R16) standard strobes stay high for accesses at or above 1 Mbyte
`timescale 1ns/1ns
`default_nettype none
`include "izw_defs.vh"
module izw_top (
    // clock, reset, enable
    input  wire                   i_clk,
    input  wire                   i_rst_n,
    input  wire                   i_ce,
    // bus state from neighbours (same clock)
    input  wire                   i_own,
    input  wire                   i_refresh,
    input  wire                   i_suspend,
    input  wire [`IZW_ADDR_W-1:0] i_addr,
    input  wire                   i_hi_byte,
    input  wire                   i_write,
    input  wire [`IZW_KIND_W-1:0] i_kind,
    input  wire                   i_start,
    input  wire [`IZW_DATA_W-1:0] i_wdata,
    // isa pins from outside the clock domain
    input  wire                   i_sysclk,
    input  wire                   i_memr_n,
    input  wire                   i_memw_n,
    input  wire                   i_zerows_n,
    input  wire                   i_iochrdy,
    input  wire                   i_sbhe_n,
    input  wire [`IZW_DATA_W-1:0] i_sd,
    // byte-high enable pin
    output reg                    o_sbhe_n,
    output reg                    o_sbhe_oe_n,
    // data pins
    output reg  [`IZW_DATA_W-1:0] o_sd,
    output reg                    o_sd_hi_oe_n,
    output reg                    o_sd_lo_oe_n,
    // standard strobes
    output reg                    o_smemr_n,
    output reg                    o_smemw_n,
    output reg                    o_smemw_oe_n,
    // results
    output reg  [`IZW_DATA_W-1:0] o_rdata,
    output reg                    o_rvalid,
    output reg                    o_hi_seen,
    output wire                   o_busy,
    output wire                   o_done,
    output wire [`IZW_LEN_W-1:0]  o_clocks
);
    // synchronised pin levels
    wire                   s_sysclk;
    wire                   s_memr_n;
    wire                   s_memw_n;
    wire                   s_zerows_n;
    wire                   s_iochrdy;
    wire                   s_sbhe_n;
    wire [`IZW_DATA_W-1:0] s_sd;

    reg                    sysclk_q;
    wire                   tick;
    reg [`IZW_SDLY_W-1:0]  rd_dly_q;
    reg [`IZW_SDLY_W-1:0]  wr_dly_q;
    reg                    std_q;
    reg                    rd_cyc_q;
    wire                   drive_sd;

    // one step of a strobe delay line: clears as soon as the full strobe
    // releases and saturates at the delay, so a long strobe never wraps
    function [`IZW_SDLY_W-1:0] dly_step;
        input                   full_n;
        input [`IZW_SDLY_W-1:0] dly;
        begin
            if (full_n)
                dly_step = {`IZW_SDLY_W{1'b0}};
            else if (dly != `IZW_SDLY)
                dly_step = dly + 3'h1;
            else
                dly_step = dly;
        end
    endfunction

    // standard strobe level, active low: only in a below-limit cycle and
    // only once the full strobe has held low for the whole delay
    function std_n;
        input                   std;
        input                   full_n;
        input [`IZW_SDLY_W-1:0] dly;
        begin
            std_n = !(std && !full_n && dly == `IZW_SDLY);
        end
    endfunction

    // bus clock pin; idles high like the strobes
    izw_sync #(.W(1), .RV(1'b1)) u_sync_clk (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_ce    (i_ce),
        .i_d     (i_sysclk),
        .o_q     (s_sysclk)
    );

    // full read strobe, idle high
    izw_sync #(.W(1), .RV(1'b1)) u_sync_memr (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_ce    (i_ce),
        .i_d     (i_memr_n),
        .o_q     (s_memr_n)
    );

    // full write strobe, idle high
    izw_sync #(.W(1), .RV(1'b1)) u_sync_memw (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_ce    (i_ce),
        .i_d     (i_memw_n),
        .o_q     (s_memw_n)
    );

    // zero-wait request, idle high so nothing is shortened after reset
    izw_sync #(.W(1), .RV(1'b1)) u_sync_zws (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_ce    (i_ce),
        .i_d     (i_zerows_n),
        .o_q     (s_zerows_n)
    );

    // ready, idle high so reset never looks like a wait state
    izw_sync #(.W(1), .RV(1'b1)) u_sync_rdy (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_ce    (i_ce),
        .i_d     (i_iochrdy),
        .o_q     (s_iochrdy)
    );

    // byte-high pin as the wire shows it, idle high
    izw_sync #(.W(1), .RV(1'b1)) u_sync_bhe (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_ce    (i_ce),
        .i_d     (i_sbhe_n),
        .o_q     (s_sbhe_n)
    );

    // data lines; content meaningless during refresh
    // own instance, since these idle low rather than high
    izw_sync #(.W(`IZW_DATA_W), .RV(1'b0)) u_sync_sd (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_ce    (i_ce),
        .i_d     (i_sd),
        .o_q     (s_sd)
    );

    // rising edge of bus clock marks one bus clock; resets to the
    // synchroniser's idle level so no false edge follows reset
    always @(posedge i_clk) begin
        if (!i_rst_n)
            sysclk_q <= 1'b1;
        else if (i_ce)
            sysclk_q <= s_sysclk;
    end
    assign tick = s_sysclk && !sysclk_q;

    // cycle length engine; ticks lag the pin by about three core
    // clocks, but every tick lags alike so the counts stay exact
    izw_zws u_zws (
        .i_clk      (i_clk),
        .i_rst_n    (i_rst_n),
        .i_ce       (i_ce),
        .i_start    (i_start),
        .i_tick     (tick),
        .i_kind     (i_kind),
        .i_zerows_n (s_zerows_n),
        .i_iochrdy  (s_iochrdy),
        .o_busy     (o_busy),
        .o_done     (o_done),
        .o_clocks   (o_clocks)
    );

    // latch below-1M qualifier at start from the address alone; refresh is masked later at the strobes
    // held for the whole cycle, so a late address change is harmless
    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            std_q    <= 1'b0;
            rd_cyc_q <= 1'b0;
        end else if (i_ce) begin
            if (i_start && !o_busy) begin
                std_q    <= (i_addr < `IZW_STD_LIMIT); // R6 R8 R16
                rd_cyc_q <= !i_write;
            end
        end
    end

    // delay lines: shift of full strobe, asserted only after it holds
    // low for the whole delay; release follows full strobe at once so
    // the standard strobe outlasts it by just one core clock
    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            rd_dly_q <= {`IZW_SDLY_W{1'b0}};
            wr_dly_q <= {`IZW_SDLY_W{1'b0}};
        end else if (i_ce) begin
            rd_dly_q <= dly_step(s_memr_n, rd_dly_q); // R7
            wr_dly_q <= dly_step(s_memw_n, wr_dly_q); // R9
        end
    end

    // standard strobes and write-strobe enable
    // the enable drops on the first edge out of reset; floats before
    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_smemr_n    <= 1'b1;
            o_smemw_n    <= 1'b1;
            o_smemw_oe_n <= 1'b1; // R10
        end else if (i_ce) begin
            o_smemw_oe_n <= 1'b0; // R10
            if (i_suspend || i_refresh) begin
                o_smemr_n <= 1'b1;
                o_smemw_n <= 1'b1; // R10
            end else begin
                o_smemr_n <= std_n(std_q, s_memr_n, rd_dly_q); // R6 R7 R16
                o_smemw_n <= std_n(std_q, s_memw_n, wr_dly_q); // R8 R9 R16
            end
        end
    end

    // byte-high enable: driven while we own the bus or in suspend
    // suspend keeps the pin driven high rather than floating
    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_sbhe_n    <= 1'b1;
            o_sbhe_oe_n <= 1'b1;
        end else if (i_ce) begin
            o_sbhe_oe_n <= !(i_own || i_suspend); // R3
            if (i_refresh || i_suspend)
                o_sbhe_n <= 1'b1; // R2
            else
                o_sbhe_n <= !i_hi_byte; // R1
        end
    end

    // data direction: drive on owned writes, never on refresh
    assign drive_sd = i_own && i_write && o_busy && !i_refresh; // R5

    // data out registers and lane enables
    // o_sd copies i_wdata each edge; only the lane enables decide
    // whether it reaches the pins, which saves a load strobe
    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_sd         <= {`IZW_DATA_W{1'b0}};
            o_sd_hi_oe_n <= 1'b1;
            o_sd_lo_oe_n <= 1'b1;
        end else if (i_ce) begin
            o_sd         <= i_wdata;
            o_sd_lo_oe_n <= !drive_sd; // R4
            o_sd_hi_oe_n <= !(drive_sd && i_hi_byte); // R4 R1
        end
    end

    // capture read data at cycle end; high byte only if it moved
    // done is registered, so the lines sampled here are only a few
    // core clocks younger than the closing bus clock edge
    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_rdata   <= {`IZW_DATA_W{1'b0}};
            o_rvalid  <= 1'b0;
            o_hi_seen <= 1'b0;
        end else if (i_ce) begin
            o_rvalid  <= 1'b0;
            // external master's byte-high enable observed as an input
            o_hi_seen <= !i_own && !s_sbhe_n && !i_refresh; // R3 R1
            if (o_done && rd_cyc_q && !i_refresh) begin // R5
                o_rvalid <= 1'b1;
                o_rdata[`IZW_LO_MSB:`IZW_LO_LSB] <=
                    s_sd[`IZW_LO_MSB:`IZW_LO_LSB]; // R4
                if (i_hi_byte)
                    o_rdata[`IZW_HI_MSB:`IZW_HI_LSB] <=
                        s_sd[`IZW_HI_MSB:`IZW_HI_LSB]; // R4
                else
                    o_rdata[`IZW_HI_MSB:`IZW_HI_LSB] <= 8'h00;
            end
        end
    end
endmodule // izw_top
`default_nettype wire

// file: tb/izw_slave.sv
// izw_slave.sv: isa slave model: bus clock, ready, zero-wait, read data
// assumes i_go pulses as each bus cycle starts
`timescale 1ns/1ns
`default_nettype none
module izw_slave (
    // bench control
    input  wire logic        i_go,
    input  wire logic        i_zws,
    input  wire logic [3:0]  i_wait_at,
    input  wire logic        i_oe_n,
    input  wire logic [15:0] i_data,
    // isa side
    output var  logic        o_sysclk,
    output var  logic        o_zerows_n,
    output var  logic        o_iochrdy,
    output var  logic [15:0] o_sd
);
    int n = 0;
    // bus clock runs free, 64 ns
    initial begin
        o_sysclk = 1'b0;
        o_iochrdy = 1'b1;
        o_zerows_n = 1'b1;
    end
    always #32 o_sysclk = !o_sysclk;
    // ticks since the cycle began; one process owns the count
    always @(posedge o_sysclk or posedge i_go) n = i_go ? 0 : n + 1;
    // change on the falling bus edge so the next rise sees it settled
    always @(negedge o_sysclk) begin
        o_iochrdy <= (n + 1 != i_wait_at);
        o_zerows_n <= !i_zws;
    end
    // released lines show the inverse, never a stale copy
    always @* o_sd = i_oe_n ? ~i_data : i_data;
endmodule // izw_slave
`default_nettype wire

// file: tb/izw_top_props.sv
// izw_top_props.sv: concurrent checks on the strobe / zero-wait block
// assumes i_ce held high; bound into every izw_top
`timescale 1ns/1ns
`default_nettype none
`include "izw_defs.vh"
module izw_top_props (
    // clock and reset
    input wire logic        i_clk,
    input wire logic        i_rst_n,
    // inputs watched
    input wire logic        i_own,
    input wire logic        i_refresh,
    input wire logic        i_suspend,
    input wire logic [23:0] i_addr,
    input wire logic        i_hi_byte,
    input wire logic [1:0]  i_kind,
    input wire logic        i_start,
    input wire logic        i_memr_n,
    input wire logic        i_memw_n,
    // outputs checked
    input wire logic        o_sbhe_n,
    input wire logic        o_sbhe_oe_n,
    input wire logic        o_smemr_n,
    input wire logic        o_smemw_n,
    input wire logic        o_smemw_oe_n,
    input wire logic        o_busy,
    input wire logic        o_done,
    input wire logic [3:0]  o_clocks
);
    logic [1:0] kind_q;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    // kind of the running cycle, for the length checks
    always @(posedge i_clk) if (i_start && !o_busy) kind_q <= i_kind;

    a_sbhe_follow: assert property (!i_refresh && !i_suspend |=>
        o_sbhe_n == !$past(i_hi_byte)) else $error("byte-high wrong");
    a_sbhe_refresh: assert property (i_refresh |=> o_sbhe_n)
        else $error("byte-high during refresh");
    a_sbhe_dir: assert property (1'b1 |=>
        o_sbhe_oe_n == !($past(i_own) || $past(i_suspend)))
        else $error("byte-high direction wrong");
    a_std_above: assert property (i_start && !o_busy &&
        i_addr >= 24'h100000 |=> (o_smemr_n && o_smemw_n) [*8])
        else $error("standard strobe above limit");
    a_rd_delay: assert property ($fell(i_memr_n) |-> o_smemr_n [*3])
        else $error("read strobe not delayed");
    a_rd_copy: assert property ($rose(i_memr_n) |-> ##[2:6] o_smemr_n)
        else $error("read strobe stuck low");
    a_wr_delay: assert property ($fell(i_memw_n) |-> o_smemw_n [*3])
        else $error("write strobe not delayed");
    a_wr_float: assert property ($rose(i_rst_n) |-> o_smemw_oe_n)
        else $error("write strobe driven in reset");
    a_wr_drive: assert property ($past(i_rst_n) |-> !o_smemw_oe_n)
        else $error("write strobe not driven");
    a_io16_len: assert property (o_done && kind_q == `IZW_KIND_IO16
        |-> o_clocks == 4'h3) else $error("io16 length changed");
    a_min_len: assert property (o_done |-> o_clocks >=
        ((kind_q == `IZW_KIND_MEM16) ? 4'h2 : 4'h3))
        else $error("cycle too short");
    a_busy_start: assert property (i_start && !o_busy |=> o_busy)
        else $error("start not taken");
endmodule // izw_top_props
bind izw_top izw_top_props izw_top_props_i (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_own(i_own),
    .i_refresh(i_refresh), .i_suspend(i_suspend), .i_addr(i_addr),
    .i_hi_byte(i_hi_byte), .i_kind(i_kind), .i_start(i_start),
    .i_memr_n(i_memr_n), .i_memw_n(i_memw_n), .o_sbhe_n(o_sbhe_n),
    .o_sbhe_oe_n(o_sbhe_oe_n), .o_smemr_n(o_smemr_n),
    .o_smemw_n(o_smemw_n), .o_smemw_oe_n(o_smemw_oe_n),
    .o_busy(o_busy), .o_done(o_done), .o_clocks(o_clocks));
`default_nettype wire

// file: tb/izw_top_tb.sv
// izw_top_tb.sv: self-checking bench for the strobe / zero-wait block
// assumes the slave model and the bound checker are compiled with it
`timescale 1ns/1ns
`default_nettype none
`include "izw_defs.vh"
module izw_top_tb;
    logic        i_clk, i_rst_n, i_ce, i_own, i_refresh, i_suspend;
    logic        i_hi_byte, i_write, i_start, i_memr_n, i_memw_n;
    logic        m_sbhe_n, rd_n, zws;
    logic [23:0] i_addr;
    logic [1:0]  i_kind;
    logic [3:0]  wait_at;
    logic [15:0] i_wdata, rd_data;
    wire         i_sysclk, i_zerows_n, i_iochrdy, i_sbhe_n, o_sbhe_n;
    wire         o_sbhe_oe_n, o_sd_hi_oe_n, o_sd_lo_oe_n, o_smemr_n;
    wire         o_smemw_n, o_smemw_oe_n, o_rvalid, o_hi_seen, o_busy;
    wire         o_done;
    wire [15:0]  i_sd, o_sd, o_rdata, s_sd;
    wire [3:0]   o_clocks;
    int          fail_count, n_compared;
    // wire levels from both parties' enables
    assign i_sd = {o_sd_hi_oe_n ? s_sd[15:8] : o_sd[15:8],
                   o_sd_lo_oe_n ? s_sd[7:0] : o_sd[7:0]};
    assign i_sbhe_n = o_sbhe_oe_n ? m_sbhe_n : o_sbhe_n;
    izw_top izw_top_i (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_own(i_own),
        .i_refresh(i_refresh), .i_suspend(i_suspend), .i_addr(i_addr),
        .i_hi_byte(i_hi_byte), .i_write(i_write), .i_kind(i_kind),
        .i_start(i_start), .i_wdata(i_wdata), .i_sysclk(i_sysclk),
        .i_memr_n(i_memr_n), .i_memw_n(i_memw_n),
        .i_zerows_n(i_zerows_n), .i_iochrdy(i_iochrdy),
        .i_sbhe_n(i_sbhe_n), .i_sd(i_sd), .o_sbhe_n(o_sbhe_n),
        .o_sbhe_oe_n(o_sbhe_oe_n), .o_sd(o_sd),
        .o_sd_hi_oe_n(o_sd_hi_oe_n), .o_sd_lo_oe_n(o_sd_lo_oe_n),
        .o_smemr_n(o_smemr_n), .o_smemw_n(o_smemw_n),
        .o_smemw_oe_n(o_smemw_oe_n), .o_rdata(o_rdata),
        .o_rvalid(o_rvalid), .o_hi_seen(o_hi_seen), .o_busy(o_busy),
        .o_done(o_done), .o_clocks(o_clocks));
    izw_slave izw_slave_i (.i_go(i_start), .i_zws(zws),
        .i_wait_at(wait_at), .i_oe_n(rd_n), .i_data(rd_data),
        .o_sysclk(i_sysclk), .o_zerows_n(i_zerows_n),
        .o_iochrdy(i_iochrdy), .o_sd(s_sd));
    // core clock, 8 ns
    initial i_clk = 1'b0;
    always #4 i_clk = !i_clk;

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wrap_up;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // one bus cycle against the tick-by-tick length model
    task automatic run_cycle(input logic [1:0] k, input logic z,
                             input logic [3:0] w);
        int full, short, t, exp;
        logic rd, mem, lo;
        full = (k == 2'h0 || k == 2'h3) ? 3 : 6;
        short = (k == 2'h0) ? 2 : 3;
        exp = 0;
        for (t = 1; exp == 0; t++)
            if (t != w && (t >= full || (z && k != 2'h3 && t >= short)))
                exp = t;
        i_write = 1'($urandom);
        i_hi_byte = 1'($urandom);
        lo = 1'($urandom);
        i_addr = {lo ? 4'h0 : 4'h8 | 4'($urandom), 20'($urandom)};
        i_wdata = 16'($urandom);
        rd_data = 16'($urandom);
        rd = !i_write;
        mem = !k[1];
        {zws, wait_at, i_kind, i_own} = {z, w, k, 1'b1};
        // start well clear of a bus clock rise so both sides count alike
        @(negedge i_sysclk);
        repeat (2) @(negedge i_clk);
        {i_start, rd_n, i_memr_n, i_memw_n} = {1'b1, !rd, !(mem && rd),
                                               !(mem && !rd)};
        @(negedge i_clk);
        i_start = 1'b0;
        @(negedge i_clk);
        chk(o_smemr_n, 1'b1);
        chk(o_smemw_n, 1'b1);
        chk(o_busy, 1'b1);
        repeat (8) @(negedge i_clk);
        chk(o_smemr_n, !(lo && mem && rd));
        chk(o_smemw_n, !(lo && mem && !rd));
        chk(o_sd_lo_oe_n, rd);
        chk(o_sd_hi_oe_n, rd || !i_hi_byte);
        if (!rd) chk(o_sd, i_wdata);
        t = 0;
        while (o_done !== 1'b1 && t < 300) begin
            @(negedge i_clk);
            t++;
        end
        chk(o_done, 1'b1);
        chk(o_clocks, 16'(exp));
        {i_memr_n, i_memw_n} = 2'h3;
        @(negedge i_clk);
        if (rd) begin
            chk(o_rvalid, 1'b1);
            chk(o_rdata, {i_hi_byte ? rd_data[15:8] : 8'h00,
                          rd_data[7:0]});
        end
        rd_n = 1'b1;
        repeat (4) @(negedge i_clk);
    endtask

    initial begin
        {i_rst_n, i_own, i_refresh, i_suspend, i_hi_byte} = 5'h00;
        {i_write, i_start, zws, i_ce} = 4'h1;
        {i_memr_n, i_memw_n, m_sbhe_n, rd_n} = 4'hf;
        {i_addr, i_kind, wait_at, i_wdata, rd_data} = 0;
        void'($urandom(93));
        repeat (16) @(negedge i_clk);
        chk(o_smemw_oe_n, 1'b1);
        i_rst_n = 1'b1;
        repeat (2) @(negedge i_clk);
        chk(o_smemw_oe_n, 1'b0);
        chk(o_smemw_n, 1'b1);
        $display("reset test done");
        repeat (40) begin
            {i_own, i_hi_byte, i_refresh, i_suspend, m_sbhe_n} = 5'($urandom);
            repeat (4) @(negedge i_clk);
            chk(o_sbhe_n, i_refresh || i_suspend || !i_hi_byte);
            chk(o_hi_seen, !(i_own || i_suspend ||
                             i_refresh || m_sbhe_n));
            chk(o_sbhe_oe_n, !(i_own || i_suspend));
            chk(o_smemw_n, 1'b1);
        end
        {i_refresh, i_suspend} = 2'h0;
        $display("byte-high test done");
        for (int k = 0; k < 4; k++)
            for (int z = 0; z < 4; z++)
                run_cycle(2'(k), z[0], (z[1] && k != 3) ?
                          (k != 0 ? 4'h3 : 4'h2) : 4'h0);
        $display("cycle test done");
        wrap_up;
    end

    // watchdog well beyond the expected run
    initial begin
        #200000;
        fail_count++;
        wrap_up;
    end
endmodule // izw_top_tb
`default_nettype wire
